/* File: verilog/lie_pkg.sv */
// Package of the line interface event unit: register indices, field positions,
// reset values, timing constants and the structs that carry pin groups.
// Assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus.
package lie_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] IDX_INT_SOURCE = 8'h03;
  localparam logic [7:0] IDX_INT_ENABLE = 8'h05;
  localparam logic [7:0] IDX_AUX_POLARITY = 8'h06;
  localparam logic [7:0] IDX_HOOK_PATH = 8'h12;
  localparam logic [7:0] IDX_LINE_CURRENT = 8'h13;
  localparam logic [7:0] IDX_GAIN_BOOST = 8'h14;
  localparam logic [7:0] IDX_FAULT_DET_EN = 8'h15;
  localparam logic [7:0] IDX_FAULT_DETAIL = 8'h1e;
  localparam logic [7:0] IDX_PLL_CONTROL = 8'h30;

  // Interrupt source and enable bit positions.
  localparam int BIT_AUX_HI = 7;
  localparam int BIT_AUX_MID = 6;
  localparam int BIT_AUX_LO = 5;
  localparam int BIT_PCM_CLK_ERR = 4;
  localparam int BIT_RING_MON = 3;
  localparam int BIT_FAULT_SUM = 2;
  localparam int BIT_SYNC_LOSS = 1;
  localparam int BIT_RING_EVENT = 0;

  // Hook and path control bits.
  localparam int BIT_HOOK_REQUEST = 7;
  localparam int BIT_DC_PATH = 6;
  localparam int BIT_AC_PATH = 5;

  // Fault detail bits, and the matching detector enables.
  localparam int BIT_UNDERVOLT = 6;
  localparam int BIT_OVERVOLT = 5;
  localparam int BIT_OVERCURR = 4;
  localparam int BIT_OVERLOAD = 3;
  localparam int BIT_EN_OVERLOAD = 7;
  localparam int BIT_EN_UNDERVOLT = 2;
  localparam int BIT_EN_OVERVOLT = 1;
  localparam int BIT_EN_OVERCURR = 0;

  // PLL control: bit 0 is a self-clearing reset strobe.
  localparam int BIT_PLL_RESET = 0;

  // Reset values and reserved masks.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] POLARITY_MASK = 8'he0;
  // The cleared synchroniser reads as a low pin, so aux levels start as already seen.
  localparam logic [7:0] EVENT_LEVEL_RST = 8'he0;

  // Ring monitor hold time.
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RING_HOLD_MS = 25;
  localparam int unsigned RING_HOLD_CYCLES = (RING_HOLD_MS * CLK_HZ) / 1000;
  localparam int RING_CNT_W = 18;

  // Raw line-side pins, all asynchronous to hclk.
  typedef struct packed {
    logic [2:0] aux_pin;
    logic pcm_clock_fault;
    logic ext_clock_fail;
    logic barrier_sync_loss;
    logic ring_beyond;
    logic undervoltage;
    logic overvoltage;
    logic overcurrent;
    logic overload;
  } lie_line_in_type;

  // Controls driven toward the line side.
  typedef struct packed {
    logic hook_request;
    logic dc_path_enable;
    logic ac_path_enable;
    logic pll_reset;
  } lie_line_ctrl_type;

  localparam int LINE_IN_W = $bits(lie_line_in_type);

endpackage : lie_pkg

/* File: verilog/lie_sync2.sv */
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes each bit is an independent level; no multi-bit coherence is given.
module lie_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : lie_sync2

/* File: verilog/lie_ring_monitor.sv */
// Ring monitor level: high while the line is beyond the ring threshold and for
// a hold time after it crosses back. Input is already synchronised to hclk.
module lie_ring_monitor #(
  parameter int unsigned HOLD_CYCLES = lie_pkg::RING_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ring_beyond,
  output logic monitor
);
  import lie_pkg::*;

  localparam logic [RING_CNT_W-1:0] HOLD_LOAD = RING_CNT_W'(HOLD_CYCLES);
  logic [RING_CNT_W-1:0] hold_cnt_reg;

  // The counter reloads while beyond and runs down once the line drops back.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt_reg <= '0;
    end else if (ring_beyond) begin
      hold_cnt_reg <= HOLD_LOAD;
    end else if (hold_cnt_reg != '0) begin
      hold_cnt_reg <= hold_cnt_reg - RING_CNT_W'(1);
    end
  end

  // Crossing again within the hold time simply reloads, keeping the level up.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor <= 1'b0;
    end else begin
      monitor <= ring_beyond || (hold_cnt_reg > RING_CNT_W'(1));
    end
  end

endmodule : lie_ring_monitor

/* File: verilog/lie_event_unit.sv */
// Event reporting and hook control of a telephone line interface, with an
// AHB-Lite register slave. Line pins are asynchronous; hclk runs at 10 MHz.
// Functional notes
// RULE1: each interrupt source owns one bit of the source register at index 0x03.
// RULE2: bits 7 to 5 report events on the three auxiliary pins.
// RULE3: bit 4 is set on a PCM bit clock error.
// RULE4: bit 2 is a summary flag of any line fault.
// RULE5: bit 1 is set on loss of barrier synchronisation.
// RULE6: bit 3 is the ring monitor, bit 0 the ring detect event.
// RULE7: reading the source register clears latched bits and releases the interrupt.
// RULE8: enable register at 0x05 gates each source with its own bit; the code gates source bit 3 with enable bit 0.
// RULE9: enable bits 7 to 5 gate the auxiliary pin interrupts.
// RULE10: polarity register 0x06 bits 7 to 5 set pin trigger level; rest reserved.
// RULE11: host reads source, saves enable, sets enable bit 3 before servicing.
// RULE12: host restores the saved enable mask after servicing all sources.
// RULE13: clearing hook, DC and AC path bits at 0x12 releases the line.
// RULE14: a temporary clock error clears when the PLL is reset.
// RULE15: a clock error from a failed external clock survives PLL reset.
// RULE16: line fault interrupts count only while off hook.
// RULE17: fault detail register 0x1E holds undervoltage, overvoltage, overcurrent, overload.
// RULE18: host reads fault detail on summary interrupt and goes on hook if set.
// RULE19: host should reset the PLL on a barrier loss interrupt.
// RULE20: on barrier failure off hook, host goes on hook then resets PLL.
// RULE21: a threshold crossing sets ring event and ring monitor and interrupts.
// RULE22: reading clears ring event; ring monitor stays while beyond threshold.
// RULE23: ring monitor holds 25 ms after crossing back, then clears.
// RULE24: interrupt output is active low while any enabled source stays latched.
// RULE25: a source whose enable is clear never asserts the interrupt; source bit 3 still asserts it with enable bit 3 clear when enable bit 0 is set.
module lie_event_unit #(
  parameter int unsigned RING_HOLD_CYCLES = lie_pkg::RING_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire lie_pkg::lie_line_in_type line_in,
  output lie_pkg::lie_line_ctrl_type line_ctrl,
  output logic irq_n
);
  import lie_pkg::*;

  // Register index from a byte address; bits 9 to 2 decode, the low two and upper bits are ignored.
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  // Rising edge of a synchronised level against its previous sample.
  function automatic logic [7:0] rise8(input logic [7:0] now, input logic [7:0] was);
    rise8 = now & ~was;
  endfunction : rise8

  // Register file.
  logic [7:0] int_source_reg;
  logic [7:0] int_source_next;
  logic [7:0] int_enable_reg;
  logic [7:0] aux_polarity_reg;
  logic [7:0] hook_path_reg;
  logic [7:0] line_current_reg;
  logic [7:0] gain_boost_reg;
  logic [7:0] fault_det_en_reg;
  logic [7:0] fault_detail_reg;
  logic pll_reset_reg;
  logic pcm_err_reg;

  // Bus state.
  logic wr_pend_reg;
  logic [7:0] wr_index_reg;
  logic [31:0] rdata_next;

  // Synchronised pins and their previous samples.
  lie_line_in_type line_sync;
  logic [7:0] event_level;
  logic [7:0] event_level_reg;
  logic [7:0] event_rise;
  logic ring_monitor;
  logic [2:0] aux_active;
  logic [3:0] fault_gated;
  logic any_fault;
  logic addr_valid;
  logic rd_take;
  logic wr_take;
  logic src_read;
  logic [7:0] src_set;
  logic [7:0] irq_mask;

  // Every pin passes two flops before any logic sees it.
  lie_sync2 #(
    .WIDTH(LINE_IN_W)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(line_in),
    .sync_out(line_sync)
  );

  // Ring monitor level with its hold timer.
  lie_ring_monitor #(
    .HOLD_CYCLES(RING_HOLD_CYCLES)
  ) u_ring (
    .hclk(hclk),
    .hresetn(hresetn),
    .ring_beyond(line_sync.ring_beyond),
    .monitor(ring_monitor) // see RULE23
  );

  // Bus request decode; a transfer is taken only while the bus is ready.
  assign addr_valid = hsel && hready && htrans[1];
  assign rd_take = addr_valid && !hwrite;
  assign wr_take = addr_valid && hwrite;
  assign src_read = rd_take && (reg_index(haddr) == IDX_INT_SOURCE); // see RULE7

  // Auxiliary pin is active at the level chosen by its polarity bit.
  assign aux_active = ~(line_sync.aux_pin ^ aux_polarity_reg[7:5]); // see RULE10

  // Fault flags are gated by their detector enables and by off hook state,
  // since readings taken on hook are not trustworthy.
  assign fault_gated[3] = line_sync.undervoltage && fault_det_en_reg[BIT_EN_UNDERVOLT];
  assign fault_gated[2] = line_sync.overvoltage && fault_det_en_reg[BIT_EN_OVERVOLT];
  assign fault_gated[1] = line_sync.overcurrent && fault_det_en_reg[BIT_EN_OVERCURR];
  assign fault_gated[0] = line_sync.overload && fault_det_en_reg[BIT_EN_OVERLOAD];
  assign any_fault = (|fault_gated) && hook_path_reg[BIT_HOOK_REQUEST]; // see RULE16

  // Levels whose rising edges are events, in source bit order.
  always_comb begin
    event_level = 8'h00;
    event_level[BIT_AUX_HI] = aux_active[2]; // see RULE2
    event_level[BIT_AUX_MID] = aux_active[1];
    event_level[BIT_AUX_LO] = aux_active[0];
    event_level[BIT_PCM_CLK_ERR] = pcm_err_reg; // see RULE3
    event_level[BIT_RING_MON] = line_sync.ring_beyond;
    event_level[BIT_FAULT_SUM] = any_fault; // see RULE4
    event_level[BIT_SYNC_LOSS] = line_sync.barrier_sync_loss; // see RULE5
    event_level[BIT_RING_EVENT] = line_sync.ring_beyond;
  end

  // Previous sample of the event levels for edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_level_reg <= EVENT_LEVEL_RST;
    end else begin
      event_level_reg <= event_level;
    end
  end

  assign event_rise = rise8(event_level, event_level_reg);

  // Set terms for the source register. Ring crossings in either direction
  // raise the ring event; the monitor and a standing clock error are levels,
  // so a read cannot clear them while their cause lasts.
  always_comb begin
    src_set = event_rise & 8'hf6; // see RULE1
    src_set[BIT_RING_EVENT] = line_sync.ring_beyond // see RULE21
      ^ event_level_reg[BIT_RING_EVENT];
    src_set[BIT_RING_MON] = ring_monitor || src_set[BIT_RING_EVENT]; // see RULE22
    src_set[BIT_PCM_CLK_ERR] = pcm_err_reg; // see RULE15
  end

  // Clear on read; a set in the same cycle wins over the clear.
  always_comb begin
    int_source_next = int_source_reg;
    if (src_read) begin
      int_source_next = 8'h00; // see RULE7
    end
    int_source_next = int_source_next | src_set;
  end

  // Interrupt source register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_source_reg <= RST_ZERO;
    end else begin
      int_source_reg <= int_source_next; // see RULE6
    end
  end

  // PCM clock error state. A PLL reset clears a transient error, but a failed
  // external clock keeps it standing regardless of how often the PLL resets.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcm_err_reg <= 1'b0;
    end else if (line_sync.ext_clock_fail || line_sync.pcm_clock_fault) begin
      // A fault seen in the same cycle as the PLL reset wins over the clear.
      pcm_err_reg <= 1'b1; // see RULE15
    end else if (pll_reset_reg) begin
      pcm_err_reg <= 1'b0; // see RULE14
    end
  end

  // Enable mask per source; the ring enable covers both ring bits, and bit 3
  // of the enable register is a service qualifier, not a source gate.
  always_comb begin
    irq_mask = int_enable_reg; // see RULE8
    irq_mask[BIT_RING_MON] = int_enable_reg[BIT_RING_EVENT];
    irq_mask[7:5] = int_enable_reg[7:5]; // see RULE9
  end

  // The interrupt pin registers the masked next source value, so it changes in the same cycle as the source register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~|(int_source_next & irq_mask); // see RULE24 see RULE25
    end
  end

  // Fault detail is a live view of the gated fault flags.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_detail_reg <= RST_ZERO;
    end else begin
      fault_detail_reg <= RST_ZERO;
      if (hook_path_reg[BIT_HOOK_REQUEST]) begin
        fault_detail_reg[BIT_UNDERVOLT] <= fault_gated[3]; // see RULE17
        fault_detail_reg[BIT_OVERVOLT] <= fault_gated[2];
        fault_detail_reg[BIT_OVERCURR] <= fault_gated[1];
        fault_detail_reg[BIT_OVERLOAD] <= fault_gated[0];
      end
    end
  end

  // Address phase capture for writes; data arrives in the following cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_index_reg <= 8'h00;
    end else begin
      wr_pend_reg <= wr_take;
      if (wr_take) begin
        wr_index_reg <= reg_index(haddr);
      end
    end
  end

  // Writable control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable_reg <= RST_ZERO;
      aux_polarity_reg <= RST_ZERO;
      hook_path_reg <= RST_ZERO;
      line_current_reg <= RST_ZERO;
      gain_boost_reg <= RST_ZERO;
      fault_det_en_reg <= RST_ZERO;
    end else if (wr_pend_reg) begin
      unique case (wr_index_reg)
        IDX_INT_ENABLE: begin
          int_enable_reg <= hwdata[7:0];
        end
        IDX_AUX_POLARITY: begin
          aux_polarity_reg <= hwdata[7:0] & POLARITY_MASK; // see RULE10
        end
        IDX_HOOK_PATH: begin
          hook_path_reg <= hwdata[7:0]; // see RULE13
        end
        IDX_LINE_CURRENT: begin
          line_current_reg <= hwdata[7:0];
        end
        IDX_GAIN_BOOST: begin
          gain_boost_reg <= hwdata[7:0];
        end
        IDX_FAULT_DET_EN: begin
          fault_det_en_reg <= hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // PLL reset strobe: one cycle high after a write of 1 to its bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_reset_reg <= 1'b0;
    end else begin
      pll_reset_reg <= wr_pend_reg && (wr_index_reg == IDX_PLL_CONTROL)
        && hwdata[BIT_PLL_RESET];
    end
  end

  // Read mux; the source register shows its value before the clear.
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_index(haddr))
      IDX_INT_SOURCE: rdata_next[7:0] = int_source_reg;
      IDX_INT_ENABLE: rdata_next[7:0] = int_enable_reg;
      IDX_AUX_POLARITY: rdata_next[7:0] = aux_polarity_reg;
      IDX_HOOK_PATH: rdata_next[7:0] = hook_path_reg;
      IDX_LINE_CURRENT: rdata_next[7:0] = line_current_reg;
      IDX_GAIN_BOOST: rdata_next[7:0] = gain_boost_reg;
      IDX_FAULT_DET_EN: rdata_next[7:0] = fault_det_en_reg;
      IDX_FAULT_DETAIL: rdata_next[7:0] = fault_detail_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase edge so the slave never
  // inserts wait states; unmapped reads return zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rdata_next;
    end
  end

  // Always ready, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Line controls; clearing the hook and path bits releases the line.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_ctrl <= '0;
    end else begin
      line_ctrl.hook_request <= hook_path_reg[BIT_HOOK_REQUEST]; // see RULE13
      line_ctrl.dc_path_enable <= hook_path_reg[BIT_DC_PATH];
      line_ctrl.ac_path_enable <= hook_path_reg[BIT_AC_PATH];
      line_ctrl.pll_reset <= pll_reset_reg; // see RULE19
    end
  end

endmodule : lie_event_unit

/* File: sim/lie_event_unit_chk.sv */
// Checker of the event unit: bus answers, interrupt output and line controls.
// Assumes it is bound to lie_event_unit and sees only the unit's ports.
module lie_event_unit_chk #(
  parameter int unsigned RING_HOLD_CYCLES = lie_pkg::RING_HOLD_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire lie_pkg::lie_line_ctrl_type line_ctrl,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import lie_pkg::*;
  logic ap;
  logic rd_src;
  logic en_wr;
  logic hk_wr;
  logic wr_dp;
  logic [7:0] wr_idx;
  logic [7:0] en_sh;
  logic [2:0] hk_sh;
  // A transfer is taken when selected, ready and non-idle.
  assign ap = hsel && hready && htrans[1];
  assign rd_src = ap && !hwrite && haddr[9:2] == IDX_INT_SOURCE;
  assign en_wr = wr_dp && wr_idx == IDX_INT_ENABLE;
  assign hk_wr = wr_dp && wr_idx == IDX_HOOK_PATH;
  // Write data arrive one cycle after the address, so the address is kept.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp <= 1'b0;
      wr_idx <= 8'h00;
    end else begin
      wr_dp <= ap && hwrite;
      wr_idx <= haddr[9:2];
    end
  end
  // Shadows of the enable and hook registers, so no internal probe is needed.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_sh <= 8'h00;
      hk_sh <= 3'h0;
    end else begin
      if (en_wr) en_sh <= hwdata[7:0];
      if (hk_wr) hk_sh <= hwdata[7:5];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  upper_bits_zero_a: assert property (ap && !hwrite |=> hrdata[31:8] == 24'h0)
    else $error("Read data upper bits are not zero.");
  pol_reserved_a: assert property (ap && !hwrite && haddr[9:2] == IDX_AUX_POLARITY
    |=> hrdata[4:0] == 5'h00) else $error("Reserved polarity bits read nonzero.");
  irq_rise_cause_a: assert property ($rose(irq_n)
    |-> $past(rd_src) || $past(en_wr) || $past(en_wr, 2))
    else $error("Interrupt released without a source read.");
  irq_hold_a: assert property (!irq_n && !rd_src && !en_wr
    && !$past(en_wr) |=> !irq_n)
    else $error("Interrupt released while sources stay latched.");
  irq_fall_enable_a: assert property ($fell(irq_n)
    |-> ($past(en_sh) & 8'hf7) != 8'h00)
    else $error("Interrupt raised with no source enabled.");
  hook_follow_a: assert property (hk_wr |=> ##[0:1] line_ctrl[3:1] == hk_sh)
    else $error("Hook and path controls do not follow the register.");
  pll_strobe_a: assert property (wr_dp && wr_idx == IDX_PLL_CONTROL && hwdata[0]
    |-> ##[1:2] line_ctrl.pll_reset) else $error("PLL reset strobe missing.");
  pll_pulse_a: assert property ($rose(line_ctrl.pll_reset) |=> !line_ctrl.pll_reset)
    else $error("PLL reset is longer than one cycle.");
  detail_onhook_a: assert property (ap && !hwrite && haddr[9:2] == IDX_FAULT_DETAIL
    && !hk_sh[2] |=> hrdata[6:3] == 4'h0) else $error("Fault detail shown while on hook.");
  irq_seen_c: cover property ($fell(irq_n));
  ring_both_c: cover property (rd_src ##1 hrdata[3:0] == 4'h9);
  pll_seen_c: cover property (line_ctrl.pll_reset);
endmodule : lie_event_unit_chk

bind lie_event_unit lie_event_unit_chk #(.RING_HOLD_CYCLES(RING_HOLD_CYCLES)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .line_ctrl(line_ctrl), .irq_n(irq_n)
);

/* File: sim/lie_line_model.sv */
// Line-side model: holds the pin levels that the bench commands.
// Assumes one hclk domain; pll_reset comes from the unit's line controls.
module lie_line_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire lie_pkg::lie_line_in_type set_in,
  input wire lie_pkg::lie_line_ctrl_type line_ctrl,
  output lie_pkg::lie_line_in_type line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import lie_pkg::*;
  // Aux pins rest high so that a zero polarity sees them idle after reset.
  // A PLL reset resyncs the barrier and ends a temporary clock fault only.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_in <= 11'h700;
    end else if (load) begin
      line_in <= set_in;
    end else if (line_ctrl.pll_reset) begin
      line_in.barrier_sync_loss <= 1'b0;
      line_in.pcm_clock_fault <= 1'b0;
    end
  end
endmodule : lie_line_model

/* File: sim/lie_event_unit_test.sv */
// Self-checking bench of the event unit over AHB-Lite, with a line model.
// Assumes a 10 MHz hclk; the ring hold is shortened to HOLD cycles.
module lie_event_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lie_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int LIMIT = 5000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic load = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic irq_n;
  lie_line_in_type set_in = 11'h700;
  lie_line_in_type line_in;
  lie_line_ctrl_type line_ctrl;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [31:0] sv;
  logic [7:0] ridx [9] = '{IDX_INT_SOURCE, IDX_INT_ENABLE, IDX_AUX_POLARITY, IDX_HOOK_PATH,
    IDX_LINE_CURRENT, IDX_GAIN_BOOST, IDX_FAULT_DET_EN, IDX_FAULT_DETAIL, 8'h07};
  // The single slave's ready is the bus ready.
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  lie_event_unit #(.RING_HOLD_CYCLES(HOLD)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .line_in(line_in), .line_ctrl(line_ctrl), .irq_n(irq_n));
  lie_line_model far (.hclk(hclk), .hresetn(hresetn), .load(load), .set_in(set_in),
    .line_ctrl(line_ctrl), .line_in(line_in));
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // One single transfer; the address is held until ready, then the data phase.
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  task automatic pins(input lie_line_in_type v);
    set_in <= v;
    load <= 1'b1;
    @(posedge hclk);
    load <= 1'b0;
    // Let an edge pass so a following call never drives load twice at once.
    @(posedge hclk);
  endtask : pins
  task automatic pin_set(input int b, input logic v);
    lie_line_in_type n;
    n = set_in;
    n[b] = v;
    pins(n);
  endtask : pin_set
  // Waits a bounded time for the interrupt level, then compares it.
  task automatic irq_is(input logic e);
    int k;
    k = 0;
    while (irq_n !== e && k < 10) begin
      @(posedge hclk);
      k++;
    end
    check({31'h0, irq_n}, {31'h0, e});
  endtask : irq_is
  // The discard read clears the bit that was latched before the reset.
  task automatic pll_clear();
    wr(IDX_PLL_CONTROL, 8'h01);
    tick(3);
    bus(IDX_INT_SOURCE, 1'b0, 8'h00);
  endtask : pll_clear
  // A hung wait counts as a mismatch and ends the run.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    check({17'h0, hrdata[7:0], hreadyout, hresp, irq_n, line_ctrl},
      {17'h0, 8'h00, 3'b101, 4'h0});
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ridx[i]) rchk(ridx[i], 8'h00);
    wr(8'h07, 8'hff);
    rchk(8'h07, 8'h00);
    wr(IDX_FAULT_DETAIL, 8'hff);
    rchk(IDX_FAULT_DETAIL, 8'h00);
    foreach (ridx[i]) if (i > 3 && i < 7) begin
      wr(ridx[i], 8'h5a);
      rchk(ridx[i], 8'h5a);
    end
    wr(IDX_AUX_POLARITY, 8'hff);
    rchk(IDX_AUX_POLARITY, 8'he0);
    tick(5);
    rchk(IDX_INT_SOURCE, 8'he0);
    irq_is(1'b1);
    wr(IDX_INT_ENABLE, 8'he0);
    pins(11'h000);
    for (int i = 0; i < 3; i++) begin
      pin_set(8 + i, 1'b1);
      irq_is(1'b0);
      rchk(IDX_INT_SOURCE, 8'h20 << i);
      irq_is(1'b1);
      pin_set(8 + i, 1'b0);
    end
    wr(IDX_INT_ENABLE, 8'h10);
    pin_set(7, 1'b1);
    pin_set(7, 1'b0);
    irq_is(1'b0);
    rchk(IDX_INT_SOURCE, 8'h10);
    pll_clear();
    rchk(IDX_INT_SOURCE, 8'h00);
    pin_set(6, 1'b1);
    irq_is(1'b0);
    pll_clear();
    rchk(IDX_INT_SOURCE, 8'h10);
    pin_set(6, 1'b0);
    pll_clear();
    rchk(IDX_INT_SOURCE, 8'h00);
    wr(IDX_INT_ENABLE, 8'h06);
    wr(IDX_HOOK_PATH, 8'he0);
    tick(2);
    check({28'h0, line_ctrl}, 32'h0000000e);
    pin_set(5, 1'b1);
    irq_is(1'b0);
    rchk(IDX_INT_SOURCE, 8'h02);
    wr(IDX_HOOK_PATH, 8'h00);
    tick(2);
    check({28'h0, line_ctrl}, 32'h0);
    pll_clear();
    pin_set(5, 1'b0);
    rchk(IDX_INT_SOURCE, 8'h00);
    wr(IDX_INT_ENABLE, 8'h04);
    wr(IDX_FAULT_DET_EN, 8'h87);
    pin_set(3, 1'b1);
    tick(6);
    irq_is(1'b1);
    rchk(IDX_FAULT_DETAIL, 8'h00);
    pin_set(3, 1'b0);
    rchk(IDX_INT_SOURCE, 8'h00);
    for (int f = 0; f < 4; f++) begin
      wr(IDX_HOOK_PATH, 8'he0);
      pin_set(f, 1'b1);
      irq_is(1'b0);
      rchk(IDX_INT_SOURCE, 8'h04);
      rchk(IDX_FAULT_DETAIL, 8'h08 << f);
      wr(IDX_HOOK_PATH, 8'h00);
      pin_set(f, 1'b0);
    end
    wr(IDX_INT_ENABLE, 8'h01);
    pin_set(4, 1'b1);
    irq_is(1'b0);
    rchk(IDX_INT_SOURCE, 8'h09);
    rchk(IDX_INT_SOURCE, 8'h08);
    irq_is(1'b0);
    bus(IDX_INT_ENABLE, 1'b0, 8'h00);
    sv = rd;
    wr(IDX_INT_ENABLE, sv[7:0] | 8'h08);
    pin_set(4, 1'b0);
    tick(4);
    rchk(IDX_INT_SOURCE, 8'h09);
    rchk(IDX_INT_SOURCE, 8'h08);
    tick(HOLD + 10);
    rchk(IDX_INT_SOURCE, 8'h08);
    rchk(IDX_INT_SOURCE, 8'h00);
    irq_is(1'b1);
    wr(IDX_INT_ENABLE, sv[7:0]);
    rchk(IDX_INT_ENABLE, 8'h01);
    test_done();
  end
endmodule : lie_event_unit_test
